// File: gupc_board.sv
// Board model: resolves each pin wire from device drive, bench drive and pull-ups
`timescale 1ns/1ps
module gupc_board
	import gupc_pkg::*;
(
	input  wire logic [gupc_pkg::NPINS-1:0] dev_out_in,
	input  wire logic [gupc_pkg::NPINS-1:0] dev_oe_in,
	input  wire logic [gupc_pkg::NPINS-1:0] ext_val_in,
	input  wire logic [gupc_pkg::NPINS-1:0] ext_en_in,
	output logic      [gupc_pkg::NPINS-1:0] level_out
);
	import gupc_pkg::*;
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			// Fighting drivers show unknown, so a wrong enable shows whenever the two levels differ
			if (dev_oe_in[i] && ext_en_in[i] && (dev_out_in[i] != ext_val_in[i]))
				level_out[i] = 1'bx;
			else if (dev_oe_in[i])
				level_out[i] = dev_out_in[i];
			else if (ext_en_in[i])
				level_out[i] = ext_val_in[i];
			else
				level_out[i] = 1'b1;
		end
	end
endmodule

// File: gupc_debounce.sv
// Per-pin input debouncer: output follows input once stable for a full period
`timescale 1ns/1ps
module gupc_debounce
	import gupc_pkg::*;
(
	input  wire logic                    clk_in,
	input  wire logic                    resetn_in,
	input  wire logic                    ce_in,
	input  wire logic [gupc_pkg::NPINS-1:0] raw_in,
	output logic      [gupc_pkg::NPINS-1:0] clean_out
);
	import gupc_pkg::*;

	typedef struct packed {
		logic [NPINS-1:0]            clean;
		logic [NPINS-1:0][DEB_W-1:0] cnt;
	} gupc_deb_t;

	gupc_deb_t st_r;
	gupc_deb_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < NPINS; i++) begin
			if (raw_in[i] == st_r.clean[i]) begin
				st_nxt.cnt[i] = '0;
			end else if (st_r.cnt[i] == DEB_W'(DEBOUNCE_CYC - 1)) begin
				st_nxt.cnt[i]   = '0;
				st_nxt.clean[i] = raw_in[i];
			end else begin
				st_nxt.cnt[i] = st_r.cnt[i] + DEB_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= '0;
		end else if (ce_in) begin
			st_r <= st_nxt;
		end
	end

	assign clean_out = st_r.clean;
endmodule

// File: gupc_pkg.sv
// Shared constants and types for the upper pin configuration block
package gupc_pkg;
	localparam int          NPINS            = 6;
	localparam int          NCFG             = 3;
	// Register indexes; byte address is four times the index
	localparam logic [7:0]  IDX_CFG_10_11    = 8'h1a;
	localparam logic [7:0]  IDX_CFG_12_13    = 8'h1b;
	localparam logic [7:0]  IDX_CFG_14_15    = 8'h1c;
	localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h20;
	localparam logic [7:0]  IDX_IRQ_CLEAR    = 8'h21;
	localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h22;
	localparam logic [7:0]  IDX_PIN_LEVEL    = 8'h23;
	localparam logic [7:0]  RST_CFG_10_11    = 8'h89;
	localparam logic [7:0]  RST_CFG_12_13    = 8'h03;
	localparam logic [7:0]  RST_CFG_14_15    = 8'h33;
	// Field positions inside one pin nibble
	localparam int          FLD_SEL_LSB      = 0;
	localparam int          FLD_TYPE         = 2;
	localparam int          FLD_MODE         = 3;
	localparam logic [1:0]  SEL_ALT          = 2'h0;
	localparam logic [1:0]  SEL_INPUT        = 2'h1;
	localparam logic [1:0]  SEL_OPEN_DRAIN   = 2'h2;
	localparam logic [1:0]  SEL_PUSH_PULL    = 2'h3;
	localparam logic [1:0]  SUP_FIRST        = 2'h0;
	localparam logic [1:0]  SUP_SECOND       = 2'h1;
	localparam logic [1:0]  SUP_CORE         = 2'h2;
	localparam int          IRQ_BITS         = 7;
	localparam int          IRQ_WAIT_TIMEOUT = 6;
	localparam int          CLK_MHZ          = 100;
	localparam int          WAIT_TIMEOUT_MS  = 500;
	localparam int          WAIT_TIMEOUT_CYC = WAIT_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int          DEBOUNCE_US      = 20;
	localparam int          DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
	localparam int          DEB_W            = 12;
	localparam int          WAIT_W           = 26;
	typedef enum logic {GUPC_WS_IDLE, GUPC_WS_RUN} gupc_ws_t;
endpackage

// File: gupc_top.sv
// Configuration and pin logic for general-purpose pins 10 to 15
// Behaviour
// - Pin10 select: 00 domain1 enable, 01 input, 10 open drain, 11 push-pull; reset 01
// - Pin10 type: 0 active low, 1 active high; output blinks from RTC when 1
// - Pin10 mode 1: debounce, wakeup, wait step times out after 500 ms; outputs level
// - Pin11 select: 00 accessory detect, 01 input, 10 open drain, 11 push-pull; reset 00
// - Pin11 type: 0 active low, 1 active high; output blinks from RTC when 1
// - Pin11 mode resets 1; accessory wakeup only on identification float falling edge
// - Pin12 select: 00 feedback wakeup, 01 input/regulator9, 10 od, 11 pp; reset 11
// - Pin12 input mode 0: no debounce, regulator9 enable follows active input
// - Pin13 select: 00 active-low supply fault, 01 input, 10 od, 11 pp; reset 00
// - Pin14 select: 00 link data forcing pin15 clock, 01 in, 10 od PWM, 11 pp
// - Pin14 in link use: mode 1 raises wakeup on each link access
// - Pin15 select: 00 link clock, 01 input, 10 od PWM, 11 push-pull; reset 11
// - Pin15 type picks link supply first/second; mode_a forces core supply
// - Input pins: mode 1 debounce and wakeup, mode 0 neither; outputs drive mode level
// - Output type 0: first supply, internal pull-up in open drain; 1: second supply, external pull-up
// - Wait step ends on pin10 enable input or timeout; idle by default
`timescale 1ns/1ps
module gupc_top
	import gupc_pkg::*;
#(
	parameter int WAIT_CYCLES = gupc_pkg::WAIT_TIMEOUT_CYC
) (
	input  wire logic                        clk_in,
	input  wire logic                        resetn_in,
	input  wire logic                        ce_in,
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [11:0]                 paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic      [31:0]                 prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	input  wire logic [gupc_pkg::NPINS-1:0]  pin_in,
	output logic      [gupc_pkg::NPINS-1:0]  pin_out,
	output logic      [gupc_pkg::NPINS-1:0]  pin_oe_out,
	output logic      [gupc_pkg::NPINS-1:0]  internal_pullup_out,
	output logic      [gupc_pkg::NPINS-1:0]  second_io_supply_out,
	input  wire logic                        rtc_blink_in,
	input  wire logic                        pwm_in,
	input  wire logic                        supply_fault_n_in,
	input  wire logic                        mode_a_in,
	input  wire logic                        link_access_in,
	input  wire logic                        link_data_low_in,
	input  wire logic                        wait_step_start_in,
	output logic                             domain1_enable_out,
	output logic                             external_wakeup_out,
	output logic                             regulator9_enable_out,
	output logic                             link_active_out,
	output logic      [1:0]                  link_supply_out,
	output logic                             link_data_out,
	output logic                             link_clk_out,
	output logic                             wait_step_done_out,
	output logic                             irq_out
);
	import gupc_pkg::*;

	typedef struct packed {
		logic [NCFG-1:0][7:0]  cfg;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
		logic [IRQ_BITS-1:0]   stat;
		logic [IRQ_BITS-1:0]   en;
		logic                  irq;
		logic [NPINS-1:0]      prev;
		logic [NPINS-1:0]      pout;
		logic [NPINS-1:0]      poe;
		logic [NPINS-1:0]      pull;
		logic [NPINS-1:0]      sup2;
		logic                  dom1;
		logic                  extw;
		logic                  reg9;
		logic                  lnk;
		logic [1:0]            lsup;
		logic                  ldata;
		logic                  lclk;
		gupc_ws_t              ws;
		logic [WAIT_W-1:0]     wcnt;
		logic                  wdone;
	} gupc_state_t;

	gupc_state_t st_r;
	gupc_state_t st_nxt;

	logic [NPINS-1:0] act_raw;
	logic [NPINS-1:0] act_deb;
	logic [NPINS-1:0] act;
	logic [NPINS-1:0] wake;
	logic             acc_setup;
	logic             acc_done;
	logic [7:0]       acc_idx;

	function automatic logic [3:0] nib(input logic [NCFG-1:0][7:0] c, input int p);
		return c[p / 2][(p % 2) * 4 +: 4];
	endfunction

	function automatic logic [1:0] sel_of(input logic [NCFG-1:0][7:0] c, input int p);
		logic [3:0] n;
		n = nib(c, p);
		return n[FLD_SEL_LSB +: 2];
	endfunction

	function automatic logic bit_of(input logic [NCFG-1:0][7:0] c, input int p, input int f);
		logic [3:0] n;
		n = nib(c, p);
		return n[f];
	endfunction

	// Type bit picks polarity: low-active pins are inverted here
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			act_raw[i] = pin_in[i] ~^ bit_of(st_r.cfg, i, FLD_TYPE);
		end
	end

	gupc_debounce u_deb (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.raw_in    (act_raw),
		.clean_out (act_deb)
	);

	// Mode 0 bypasses the filter so regulator9 follows the pin at once
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			act[i] = bit_of(st_r.cfg, i, FLD_MODE) ? act_deb[i] : act_raw[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			wake[i] = 1'b0;
			if (bit_of(st_r.cfg, i, FLD_MODE) && !bit_of(st_r.cfg, i, FLD_SEL_LSB + 1)) begin
				wake[i] = act[i] && !st_r.prev[i];
			end
		end
		if (sel_of(st_r.cfg, 1) == SEL_ALT) begin
			wake[1] = bit_of(st_r.cfg, 1, FLD_MODE) && !act[1] && st_r.prev[1];
		end
		if (sel_of(st_r.cfg, 3) == SEL_ALT) begin
			wake[3] = 1'b0;
		end
		if (sel_of(st_r.cfg, 4) == SEL_ALT) begin
			wake[4] = bit_of(st_r.cfg, 4, FLD_MODE) && link_access_in;
		end
		if (sel_of(st_r.cfg, 4) == SEL_ALT || sel_of(st_r.cfg, 5) == SEL_ALT) begin
			wake[5] = 1'b0;
		end
	end

	assign acc_setup = psel_in && !penable_in;
	assign acc_done  = psel_in && penable_in && st_r.pready;
	assign acc_idx   = paddr_in[9:2];

	always_comb begin
		logic [1:0] s;
		logic       lvl;
		logic       od;
		s   = '0;
		lvl = 1'b0;
		od  = 1'b0;
		st_nxt = st_r;
		// Answer one cycle after the access phase starts
		st_nxt.pready  = psel_in && penable_in && !st_r.pready;
		st_nxt.pslverr = 1'b0;
		if (psel_in && penable_in && !st_r.pready) begin
			st_nxt.prdata = '0;
			case (acc_idx)
				IDX_CFG_10_11:  st_nxt.prdata[7:0] = st_r.cfg[0];
				IDX_CFG_12_13:  st_nxt.prdata[7:0] = st_r.cfg[1];
				IDX_CFG_14_15:  st_nxt.prdata[7:0] = st_r.cfg[2];
				IDX_IRQ_STATUS: st_nxt.prdata[IRQ_BITS-1:0] = st_r.stat;
				IDX_IRQ_CLEAR:  st_nxt.prdata = '0;
				IDX_IRQ_ENABLE: st_nxt.prdata[IRQ_BITS-1:0] = st_r.en;
				IDX_PIN_LEVEL:  st_nxt.prdata[NPINS-1:0] = st_r.prev;
				default:        st_nxt.pslverr = 1'b1;
			endcase
			if (paddr_in[1:0] != 2'h0 || paddr_in[11:10] != 2'h0) begin
				st_nxt.pslverr = 1'b1;
			end
		end
		if (acc_done && pwrite_in && !st_r.pslverr) begin
			case (acc_idx)
				IDX_CFG_10_11:  st_nxt.cfg[0] = pwdata_in[7:0];
				IDX_CFG_12_13:  st_nxt.cfg[1] = pwdata_in[7:0];
				IDX_CFG_14_15:  st_nxt.cfg[2] = pwdata_in[7:0];
				IDX_IRQ_CLEAR:  st_nxt.stat = st_r.stat & ~pwdata_in[IRQ_BITS-1:0];
				IDX_IRQ_ENABLE: st_nxt.en = pwdata_in[IRQ_BITS-1:0];
				default:        st_nxt.stat = st_r.stat;
			endcase
		end

		// Wait step of the sequencer
		st_nxt.wdone = 1'b0;
		case (st_r.ws)
			GUPC_WS_IDLE: begin
				st_nxt.wcnt = '0;
				if (wait_step_start_in) begin
					st_nxt.ws = GUPC_WS_RUN;
				end
			end
			GUPC_WS_RUN: begin
				st_nxt.wcnt = st_r.wcnt + WAIT_W'(1);
				if (sel_of(st_r.cfg, 0) == SEL_ALT && act[0]) begin
					st_nxt.ws    = GUPC_WS_IDLE;
					st_nxt.wdone = 1'b1;
				end else if (bit_of(st_r.cfg, 0, FLD_MODE)
					&& st_r.wcnt == WAIT_W'(WAIT_CYCLES - 1)) begin
					st_nxt.ws    = GUPC_WS_IDLE;
					st_nxt.wdone = 1'b1;
					st_nxt.stat[IRQ_WAIT_TIMEOUT] = 1'b1;
				end
			end
			default: st_nxt.ws = GUPC_WS_IDLE;
		endcase

		// Events set after the clear so a coincident event survives
		st_nxt.stat[NPINS-1:0] = st_nxt.stat[NPINS-1:0] | wake;
		st_nxt.irq  = |(st_nxt.stat & st_r.en);
		st_nxt.prev = act;

		for (int i = 0; i < NPINS; i++) begin
			s   = sel_of(st_r.cfg, i);
			lvl = bit_of(st_r.cfg, i, FLD_MODE);
			if (i < 2 && bit_of(st_r.cfg, i, FLD_TYPE)) begin
				lvl = rtc_blink_in;
			end
			if (i >= 4 && s == SEL_OPEN_DRAIN) begin
				lvl = lvl && pwm_in;
			end
			od = (s == SEL_OPEN_DRAIN);
			st_nxt.pout[i] = (s == SEL_PUSH_PULL) && lvl;
			st_nxt.poe[i]  = (s == SEL_PUSH_PULL) || (od && !lvl);
			st_nxt.pull[i] = od && !bit_of(st_r.cfg, i, FLD_TYPE);
			st_nxt.sup2[i] = bit_of(st_r.cfg, i, FLD_TYPE);
		end
		// Active-low fault output, driven push-pull
		if (sel_of(st_r.cfg, 3) == SEL_ALT) begin
			st_nxt.pout[3] = supply_fault_n_in;
			st_nxt.poe[3]  = 1'b1;
		end
		st_nxt.lnk = sel_of(st_r.cfg, 4) == SEL_ALT;
		if (st_nxt.lnk) begin
			st_nxt.pout[4] = 1'b0;
			st_nxt.poe[4]  = link_data_low_in;
			st_nxt.pout[5] = 1'b0;
			st_nxt.poe[5]  = 1'b0;
		end else if (sel_of(st_r.cfg, 5) == SEL_ALT) begin
			st_nxt.pout[5] = 1'b0;
			st_nxt.poe[5]  = 1'b0;
		end
		st_nxt.lsup  = mode_a_in ? SUP_CORE
			: (bit_of(st_r.cfg, 5, FLD_TYPE) ? SUP_SECOND : SUP_FIRST);
		st_nxt.ldata = pin_in[4];
		st_nxt.lclk  = pin_in[5];
		st_nxt.dom1  = (sel_of(st_r.cfg, 0) == SEL_ALT) && act[0];
		st_nxt.extw  = (sel_of(st_r.cfg, 2) == SEL_ALT) && act[2];
		st_nxt.reg9  = (sel_of(st_r.cfg, 2) == SEL_INPUT)
			&& !bit_of(st_r.cfg, 2, FLD_MODE) && act[2];
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r        <= '0;
			st_r.cfg[0] <= RST_CFG_10_11;
			st_r.cfg[1] <= RST_CFG_12_13;
			st_r.cfg[2] <= RST_CFG_14_15;
			st_r.ws     <= GUPC_WS_IDLE;
		end else if (ce_in) begin
			st_r <= st_nxt;
		end
	end

	assign prdata_out            = st_r.prdata;
	assign pready_out            = st_r.pready;
	assign pslverr_out           = st_r.pslverr;
	assign pin_out               = st_r.pout;
	assign pin_oe_out            = st_r.poe;
	assign internal_pullup_out   = st_r.pull;
	assign second_io_supply_out  = st_r.sup2;
	assign domain1_enable_out    = st_r.dom1;
	assign external_wakeup_out   = st_r.extw;
	assign regulator9_enable_out = st_r.reg9;
	assign link_active_out       = st_r.lnk;
	assign link_supply_out       = st_r.lsup;
	assign link_data_out         = st_r.ldata;
	assign link_clk_out          = st_r.lclk;
	assign wait_step_done_out    = st_r.wdone;
	assign irq_out               = st_r.irq;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	property p_pready_pulse;
		ce_in && pready_out |=> !pready_out || !ce_in;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than a cycle");

	property p_cfg_write;
		ce_in && acc_done && pwrite_in && !pslverr_out && acc_idx == IDX_CFG_12_13
			|=> st_r.cfg[1] == $past(pwdata_in[7:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	property p_reg9;
		ce_in && sel_of(st_r.cfg, 2) == SEL_INPUT && !bit_of(st_r.cfg, 2, FLD_MODE)
			|=> !ce_in || regulator9_enable_out == $past(act_raw[2]);
	endproperty
	a_reg9: assert property (p_reg9) else $error("regulator9 not following pin");

	property p_pp_drive;
		ce_in && sel_of(st_r.cfg, 1) == SEL_PUSH_PULL && !bit_of(st_r.cfg, 1, FLD_TYPE)
			|=> !ce_in || (pin_oe_out[1] && pin_out[1] == $past(bit_of(st_r.cfg, 1, FLD_MODE)));
	endproperty
	a_pp_drive: assert property (p_pp_drive) else $error("push-pull level wrong");

	property p_od_pull;
		ce_in && sel_of(st_r.cfg, 0) == SEL_OPEN_DRAIN
			|=> !ce_in || (!pin_out[0] && internal_pullup_out[0] == $past(!bit_of(st_r.cfg, 0, FLD_TYPE)));
	endproperty
	a_od_pull: assert property (p_od_pull) else $error("open drain pull-up wrong");

	property p_link_sup;
		ce_in && mode_a_in |=> !ce_in || link_supply_out == SUP_CORE;
	endproperty
	a_link_sup: assert property (p_link_sup) else $error("link not on core supply");

	property p_acc_wake;
		ce_in && sel_of(st_r.cfg, 1) == SEL_ALT && act[1]
			|=> !ce_in || !st_r.stat[1] || $past(st_r.stat[1]) || !act[1] == 1'b1;
	endproperty
	a_acc_wake: assert property (p_acc_wake) else $error("accessory wakeup on rising edge");

	property p_link_wake;
		ce_in && sel_of(st_r.cfg, 4) == SEL_ALT && bit_of(st_r.cfg, 4, FLD_MODE) && link_access_in
			|=> st_r.stat[4] || !$past(ce_in);
	endproperty
	a_link_wake: assert property (p_link_wake) else $error("link access gave no wakeup");

	property p_irq_level;
		ce_in && |(st_r.stat & st_r.en) |=> irq_out || !$past(ce_in) || $past(acc_done);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output low");

	property p_wait_end;
		ce_in && st_r.ws == GUPC_WS_RUN && sel_of(st_r.cfg, 0) == SEL_ALT && act[0]
			|=> !ce_in || (wait_step_done_out && st_r.ws == GUPC_WS_IDLE);
	endproperty
	a_wait_end: assert property (p_wait_end) else $error("wait step not ended");

	c_write: cover property (acc_done && pwrite_in);
	c_wake:  cover property (|st_r.stat && irq_out);
	c_wait:  cover property (wait_step_done_out);
	c_link:  cover property (link_active_out && link_access_in);
endmodule

// File: gupc_top_tb_top.sv
// Self-checking bench for the upper pin configuration block
`timescale 1ns/1ps
module gupc_top_tb_top;
	import gupc_pkg::*;
	localparam int WAITC = 50;
	logic             clk_in, resetn_in, psel, penable, pwrite, pready, pslverr, irq, err;
	logic             rtc_blink, pwm, fault_n, mode_a, link_acc, link_low, wstart;
	logic             reg9, dom1, ext_wake, link_act, link_dat, link_clk, wdone;
	logic [1:0]       link_sup;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [NPINS-1:0] pin_lvl, pout, poe, ppull, psup, ext_val, ext_en;
	int               mismatches, cmp_count;

	gupc_top #(.WAIT_CYCLES(WAITC)) gupc_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.ce_in(1'b1), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pin_in(pin_lvl), .pin_out(pout), .pin_oe_out(poe),
		.internal_pullup_out(ppull), .second_io_supply_out(psup), .rtc_blink_in(rtc_blink),
		.pwm_in(pwm), .supply_fault_n_in(fault_n), .mode_a_in(mode_a),
		.link_access_in(link_acc), .link_data_low_in(link_low),
		.wait_step_start_in(wstart), .domain1_enable_out(dom1),
		.external_wakeup_out(ext_wake), .regulator9_enable_out(reg9),
		.link_active_out(link_act), .link_supply_out(link_sup), .link_data_out(link_dat),
		.link_clk_out(link_clk), .wait_step_done_out(wdone), .irq_out(irq));
	gupc_board gupc_board_inst (.dev_out_in(pout), .dev_oe_in(poe), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .level_out(pin_lvl));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(n < 20), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(32'(err), 32'h0);
	endtask

	task automatic pulse_access();
		@(posedge clk_in);
		link_acc <= 1'b1;
		@(posedge clk_in);
		link_acc <= 1'b0;
		tick(3);
	endtask

	task automatic t_reset();
		@(posedge clk_in);
		resetn_in <= 1'b0;
		ext_en <= '0;
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		rdchk(12'h068, 32'h89);
		rdchk(12'h06c, 32'h03);
		rdchk(12'h070, 32'h33);
		tick(1);
		chk(poe & 6'h37, 6'h34);
		chk(pout & 6'h34, 6'h00);
	endtask

	task automatic t_bus();
		apb(1'b1, 12'h06c, 32'h5a);
		rdchk(12'h06c, 32'h5a);
		apb(1'b0, 12'h090, 32'h0);
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h069, 32'hff);
		chk(32'(err), 32'h1);
		rdchk(12'h06c, 32'h5a);
		rdchk(12'h084, 32'h0);
		tick(2);
		chk({poe[2], ppull[2], psup[3]}, 3'b011);
		apb(1'b1, 12'h06c, 32'h06);
		tick(2);
		chk({poe[2], pout[2], ppull[2], psup[2]}, 4'b1001);
		apb(1'b1, 12'h06c, 32'h0b);
		tick(2);
		chk({poe[2], pout[2]}, 2'b11);
	endtask

	task automatic t_reg9();
		// Glitch-mask bit lives outside this block, so no write for it here
		apb(1'b1, 12'h06c, 32'h01);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_in);
			ext_en[2] <= 1'b1;
			ext_val[2] <= v[0];
			fault_n <= v[0];
			tick(4);
			chk({reg9, pin_lvl[3]}, {~v[0], v[0]});
		end
		apb(1'b1, 12'h06c, 32'h04);
		tick(2);
		chk({ext_wake, reg9}, 2'b10);
	endtask

	task automatic t_link();
		apb(1'b1, 12'h070, 32'h78);
		apb(1'b1, 12'h084, 32'h7f);
		tick(2);
		chk({link_act, link_sup}, 3'b101);
		@(posedge clk_in);
		mode_a <= 1'b1;
		link_low <= 1'b1;
		tick(3);
		chk(link_sup, 2'h2);
		chk({pin_lvl[4], link_dat, link_clk}, 3'b001);
		@(posedge clk_in);
		mode_a <= 1'b0;
		link_low <= 1'b0;
		pulse_access();
		rdchk(12'h080, 32'h10);
		chk(irq, 1'b0);
		apb(1'b1, 12'h088, 32'h10);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, 12'h084, 32'h10);
		tick(2);
		chk(irq, 1'b0);
		apb(1'b1, 12'h070, 32'h70);
		pulse_access();
		rdchk(12'h080, 32'h0);
	endtask

	task automatic t_outputs();
		apb(1'b1, 12'h070, 32'h3a);
		apb(1'b1, 12'h068, 32'hb7);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_in);
			pwm <= v[0];
			rtc_blink <= v[0];
			tick(3);
			chk({pin_lvl[4], pin_lvl[0], ppull[4], pin_lvl[1]}, {v[0], v[0], 2'b11});
		end
	endtask

	task automatic t_wait_timeout();
		int n = 0;
		apb(1'b1, 12'h068, 32'h89);
		apb(1'b1, 12'h084, 32'h7f);
		@(posedge clk_in);
		wstart <= 1'b1;
		@(posedge clk_in);
		wstart <= 1'b0;
		do begin
			@(posedge clk_in);
			n++;
		end while (wdone !== 1'b1 && n < 200);
		chk(32'(n >= WAITC && n <= WAITC + 3), 32'h1);
		apb(1'b0, 12'h080, 32'h0);
		chk(rd & 32'h40, 32'h40);
	endtask

	task automatic t_wait_enable();
		int n = 0;
		int seen = 0;
		apb(1'b1, 12'h068, 32'h84);
		@(posedge clk_in);
		ext_en[0] <= 1'b1;
		ext_val[0] <= 1'b0;
		wstart <= 1'b1;
		@(posedge clk_in);
		wstart <= 1'b0;
		// Longer than the timeout: mode 0 must not end the step
		repeat (80) begin
			@(posedge clk_in);
			seen += int'(wdone === 1'b1);
		end
		chk(32'(seen), 32'h0);
		chk(dom1, 1'b0);
		ext_val[0] <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (wdone !== 1'b1 && n < 10);
		chk(32'(n < 10), 32'h1);
		tick(1);
		chk(dom1, 1'b1);
	endtask

	initial begin
		#100000;
		mismatches++;
		test_done();
	end

	initial begin
		resetn_in = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rtc_blink, mode_a, link_acc, link_low, wstart} = '0;
		pwm = 1'b1;
		fault_n = 1'b1;
		ext_val = '0;
		ext_en = '0;
		mismatches = 0;
		cmp_count = 0;
		t_reset();
		t_bus();
		t_reg9();
		t_link();
		t_outputs();
		t_wait_timeout();
		t_wait_enable();
		t_reset();
		test_done();
	end
endmodule
